// ==== hw/fmq_pkg.sv ====
// shared constants, codes and register map for the indicator and queue control ends
package fmq_pkg;

  // ----------------------------------------------------------------
  // clock plan
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SYMBOL_CLOCK_HZ = 25_000_000;
  localparam int BYTE_CLOCK_HZ = 12_500_000;
  localparam int SYMBOL_DIV = CLK_HZ / SYMBOL_CLOCK_HZ;
  localparam int BYTE_DIV = CLK_HZ / BYTE_CLOCK_HZ;

  // ----------------------------------------------------------------
  // device register indexes on the device port
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_MODE_ONE = 4'h0;
  localparam logic [3:0] REG_MODE_TWO = 4'h1;
  localparam logic [3:0] REG_MODE_THREE = 4'h2;
  localparam logic [3:0] REG_CMD_ONE = 4'h3;
  localparam logic [3:0] REG_CMD_TWO = 4'h4;
  localparam logic [3:0] REG_STATUS_ONE_UPPER = 4'h5;
  localparam logic [3:0] REG_STATUS_ONE_LOWER = 4'h6;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int M1_OSM_LO = 12;
  localparam logic [2:0] OSM_CODE = 3'h2;
  localparam int M2_BYTE_ORDER = 11;
  localparam int M2_TAG_MODE = 15;
  localparam int M3_QUAL_EN = 2;
  localparam int M3_IND_LO = 4;
  localparam int M3_AFULL_REPEAT = 7;
  localparam int M3_DUAL_RX = 11;
  localparam int M3_FC_POS_LO = 12;
  localparam logic [15:0] MODE_ONE_RESET = 16'h0000;
  localparam logic [15:0] MODE_TWO_RESET = 16'h8000;
  localparam logic [15:0] MODE_THREE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD1_FLUSH_SYNC = 8'h10;
  localparam logic [7:0] CMD1_FLUSH_ASYNC0 = 8'h11;
  localparam logic [7:0] CMD1_FLUSH_ASYNC1 = 8'h12;
  localparam logic [7:0] CMD1_RSVD_FOURTH = 8'h18;
  localparam logic [7:0] CMD2_FLUSH_ALL = 8'h04;
  localparam logic [7:0] CMD2_RSVD_SYNC = 8'h01;
  localparam logic [7:0] CMD2_RSVD_ASYNC0 = 8'h02;
  localparam logic [7:0] CMD2_RSVD_FOURTH = 8'h08;

  // ----------------------------------------------------------------
  // indicator select, queue status and host request codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IND_LEGACY = 2'b00,
    IND_ONLINE = 2'b01,
    IND_SPECIAL = 2'b10,
    IND_OFF = 2'b11
  } fmq_ind_t;

  typedef enum logic [2:0] {
    QS_IDLE = 3'b000,
    QS_SYNC = 3'b001,
    QS_ASYNC0 = 3'b010,
    QS_ASYNC1 = 3'b011,
    QS_RESERVED = 3'b100,
    QS_UNDERRUN = 3'b101,
    QS_FULL = 3'b110,
    QS_AFULL = 3'b111
  } fmq_qstat_t;

  typedef enum logic [2:0] {
    HR_NONE = 3'b000,
    HR_WR_SYNC = 3'b101,
    HR_WR_ASYNC0 = 3'b110,
    HR_WR_ASYNC1 = 3'b111
  } fmq_hreq_t;

  // ----------------------------------------------------------------
  // controller register map on the AHB-Lite side
  // ----------------------------------------------------------------
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_DREG = 8'h04;
  localparam logic [7:0] H_MATCH = 8'h08;
  localparam logic [7:0] H_HREQ = 8'h0C;
  localparam logic [7:0] H_FCWORD = 8'h10;
  localparam int HD_ADDR_LO = 16;
  localparam int HD_WRITE = 20;

endpackage : fmq_pkg

// ==== hw/fmq_if.sv ====
// link between the device end and the controller end
interface fmq_if (
  input wire logic hclk,
  input wire logic hresetn
);
  logic symbol_clock_en;
  logic byte_clock_en;
  logic buffer_memory_clock_en;
  logic reg_sel;
  logic reg_write;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic frame_eval;
  logic internal_address_match;
  logic external_address_match_n;
  logic external_match_qualifier_n;
  logic a_in;
  logic c_in;
  logic a_flag;
  logic c_flag;
  logic a_out;
  logic c_out;
  logic [2:0] host_service_request;
  logic [2:0] queue_status_code;
  logic fc_strobe;
  logic [31:0] fc_word;
  logic [7:0] fc_byte;
  logic [1:0] da_lane;
  logic da_next_word;

  modport dev (
    input symbol_clock_en, byte_clock_en, buffer_memory_clock_en,
    input reg_sel, reg_write, reg_addr, reg_wdata, output reg_rdata,
    input frame_eval, internal_address_match, external_address_match_n,
    input external_match_qualifier_n, a_in, c_in,
    output a_flag, c_flag, a_out, c_out,
    input host_service_request, output queue_status_code,
    input fc_strobe, fc_word, output fc_byte, da_lane, da_next_word
  );

  modport host (
    output symbol_clock_en, byte_clock_en, buffer_memory_clock_en,
    output reg_sel, reg_write, reg_addr, reg_wdata, input reg_rdata,
    output frame_eval, internal_address_match, external_address_match_n,
    output external_match_qualifier_n, a_in, c_in,
    input a_flag, c_flag, a_out, c_out,
    output host_service_request, input queue_status_code,
    output fc_strobe, fc_word, input fc_byte, da_lane, da_next_word
  );
endinterface : fmq_if

// ==== hw/fmq_device.sv ====
// device end: mode registers, indicator setting, transmit queues, frame control position
//
// Contract
// - system supplies 25 MHz symbol clock
// - system supplies 12.5 MHz byte clock
// - buffer clock tied to byte or symbol
// - select, qualifier enable, special mode field positions
// - select 00: legacy, special mode spares A
// - select 01: online setting unless qualifier off
// - select 10: special setting unless qualifier on
// - select 11: flags zero, bits untouched
// - internal match sets everything unless 11
// - no match: flags clear, bits pass
// - external match inputs are active low
// - only three transmit queues exist
// - command codes 18 and 08 do nothing
// - fourth queue status bits read zero
// - queue status 100 never driven
// - request 111 writes asynchronous queue one
// - request 111 reports queue status 011
// - almost full repeats each write when enabled
// - frame control position resets zero, top byte
// - position picks byte, order bit reverses
// - status one bits 7:4 read zero
// - command two codes 01, 02 do nothing
// - tag mode bit resets one
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
module fmq_device #(
  parameter int QDEPTH = 16,
  parameter int AFULL_LEVEL = 12
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  fmq_if.dev lnk
);
  import fmq_pkg::*;

  localparam int NQ = 3;
  localparam int CW = $clog2(QDEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(QDEPTH);
  localparam logic [CW-1:0] AFULL_C = CW'(AFULL_LEVEL);

  if (QDEPTH < 2 || AFULL_LEVEL < 1 || AFULL_LEVEL >= QDEPTH) begin : g_bad_cfg
    $error("fmq_device: almost full level must lie inside the queue depth");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // request code to queue index, NQ when no write
  function automatic logic [1:0] req_queue(input logic [2:0] code);
    case (code)
      HR_WR_SYNC: req_queue = 2'd0;
      HR_WR_ASYNC0: req_queue = 2'd1;
      HR_WR_ASYNC1: req_queue = 2'd2;
      default: req_queue = 2'd3;
    endcase
  endfunction : req_queue

  // lane counted from the most significant byte
  function automatic logic [1:0] fc_lane(input logic [1:0] pos, input logic rev);
    fc_lane = (rev && pos != 2'd0) ? 2'(3'd4 - {1'b0, pos}) : pos;
  endfunction : fc_lane

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] mode1_r;
  logic [15:0] mode2_r;
  logic [15:0] mode3_r;
  logic [CW-1:0] qcnt_r [NQ];
  logic wr_en;
  logic [NQ-1:0] flush;
  logic [NQ-1:0] q_empty;
  logic [NQ-1:0] q_full;

  assign wr_en = lnk.reg_sel && lnk.reg_write;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode1_r <= MODE_ONE_RESET;
      mode2_r <= MODE_TWO_RESET;
      mode3_r <= MODE_THREE_RESET;
    end else if (wr_en) begin
      case (lnk.reg_addr)
        REG_MODE_ONE: mode1_r <= lnk.reg_wdata;
        REG_MODE_TWO: mode2_r <= lnk.reg_wdata;
        REG_MODE_THREE: mode3_r <= lnk.reg_wdata;
        default: ;
      endcase
    end
  end

  // commands; reserved codes fall to the default and do nothing
  always_comb begin
    flush = '0;
    if (wr_en && lnk.reg_addr == REG_CMD_ONE) begin
      case (lnk.reg_wdata[7:0])
        CMD1_FLUSH_SYNC: flush = 3'b001;
        CMD1_FLUSH_ASYNC0: flush = 3'b010;
        CMD1_FLUSH_ASYNC1: flush = 3'b100;
        default: flush = '0;
      endcase
    end else if (wr_en && lnk.reg_addr == REG_CMD_TWO) begin
      case (lnk.reg_wdata[7:0])
        CMD2_FLUSH_ALL: flush = 3'b111;
        default: flush = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.reg_rdata <= 16'h0000;
    end else if (lnk.reg_sel && !lnk.reg_write) begin
      case (lnk.reg_addr)
        REG_MODE_ONE: lnk.reg_rdata <= mode1_r;
        REG_MODE_TWO: lnk.reg_rdata <= mode2_r;
        REG_MODE_THREE: lnk.reg_rdata <= mode3_r;
        // only three queues report; bits 7:4 and above stay zero
        REG_STATUS_ONE_UPPER: lnk.reg_rdata <= {13'h0, q_empty};
        REG_STATUS_ONE_LOWER: lnk.reg_rdata <= {13'h0, q_full};
        default: lnk.reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit queues
  // ----------------------------------------------------------------
  logic [1:0] wq;
  logic [1:0] dq;
  logic host_wr;

  assign wq = req_queue(lnk.host_service_request);
  assign host_wr = lnk.buffer_memory_clock_en && wq != 2'd3;

  always_comb begin
    dq = 2'd3;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (qcnt_r[i] != '0) begin
        dq = 2'(i);
      end
    end
  end

  // sync, async0, async1 only: the fourth queue has no storage at all
  for (genvar g = 0; g < NQ; g++) begin : g_q
    logic inc;
    logic dec;
    assign q_empty[g] = qcnt_r[g] == '0;
    assign q_full[g] = qcnt_r[g] == DEPTH_C;
    assign inc = host_wr && wq == 2'(g) && !q_full[g];
    assign dec = lnk.byte_clock_en && dq == 2'(g);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        qcnt_r[g] <= '0;
      end else if (flush[g]) begin
        qcnt_r[g] <= '0;
      end else if (inc && !dec) begin
        qcnt_r[g] <= qcnt_r[g] + 1'b1;
      end else if (dec && !inc) begin
        qcnt_r[g] <= qcnt_r[g] - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // queue status on each host write cycle
  // ----------------------------------------------------------------
  logic [CW-1:0] wcnt;
  logic [2:0] qs_nxt;

  always_comb begin
    wcnt = (wq == 2'd3) ? '0 : qcnt_r[wq];
    qs_nxt = QS_IDLE;
    if (host_wr) begin
      if (wcnt >= DEPTH_C - 1'b1) begin
        qs_nxt = QS_FULL;
      end else if (mode3_r[M3_AFULL_REPEAT] && wcnt + 1'b1 >= AFULL_C) begin
        qs_nxt = QS_AFULL;
      end else if (wcnt + 1'b1 == AFULL_C) begin
        qs_nxt = QS_AFULL;
      end else begin
        // 100 is never produced; async1 always answers 011
        case (wq)
          2'd0: qs_nxt = QS_SYNC;
          2'd1: qs_nxt = QS_ASYNC0;
          default: qs_nxt = QS_ASYNC1;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.queue_status_code <= QS_IDLE;
    end else if (lnk.buffer_memory_clock_en) begin
      lnk.queue_status_code <= qs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // A and C indicators
  // ----------------------------------------------------------------
  logic ext_match;
  logic qual;
  logic online_special_mode;
  logic full_set;
  fmq_ind_t sel;

  assign ext_match = !lnk.external_address_match_n;
  assign qual = !lnk.external_match_qualifier_n;
  assign online_special_mode = mode1_r[M1_OSM_LO +: 3] == OSM_CODE;
  assign sel = fmq_ind_t'(mode3_r[M3_IND_LO +: 2]);

  always_comb begin
    case (sel)
      IND_LEGACY: full_set = !online_special_mode;
      IND_ONLINE: full_set = !(mode3_r[M3_QUAL_EN] && !qual);
      IND_SPECIAL: full_set = mode3_r[M3_QUAL_EN] && qual;
      default: full_set = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.a_flag <= 1'b0;
      lnk.c_flag <= 1'b0;
      lnk.a_out <= 1'b0;
      lnk.c_out <= 1'b0;
    end else if (lnk.frame_eval) begin
      if (sel == IND_OFF || (!lnk.internal_address_match && !ext_match)) begin
        lnk.a_flag <= 1'b0;
        lnk.c_flag <= 1'b0;
        lnk.a_out <= lnk.a_in;
        lnk.c_out <= lnk.c_in;
      end else if (lnk.internal_address_match || full_set) begin
        lnk.a_flag <= 1'b1;
        lnk.c_flag <= 1'b1;
        lnk.a_out <= 1'b1;
        lnk.c_out <= 1'b1;
      end else begin
        lnk.a_flag <= 1'b0;
        lnk.c_flag <= 1'b1;
        lnk.a_out <= lnk.a_in;
        lnk.c_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame control byte of the first data long word
  // ----------------------------------------------------------------
  logic [1:0] lane;
  assign lane = fc_lane(mode3_r[M3_FC_POS_LO +: 2], mode2_r[M2_BYTE_ORDER]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.fc_byte <= 8'h00;
      lnk.da_lane <= 2'h0;
      lnk.da_next_word <= 1'b0;
    end else if (lnk.fc_strobe) begin
      lnk.fc_byte <= lnk.fc_word[8 * (3 - lane) +: 8];
      lnk.da_lane <= lane + 2'd1;
      lnk.da_next_word <= lane == 2'd3;
    end
  end

endmodule : fmq_device

// ==== hw/fmq_host.sv ====
// controller end: AHB-Lite registers driving clocks, device port, matches and requests
module fmq_host (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // link
  fmq_if.host lnk
);
  import fmq_pkg::*;

  // ----------------------------------------------------------------
  // clock enables from dividers
  // ----------------------------------------------------------------
  logic [2:0] div_r;
  logic bm_fast_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 3'h0;
    end else begin
      div_r <= (div_r == 3'(BYTE_DIV - 1)) ? 3'h0 : div_r + 3'h1;
    end
  end

  assign lnk.symbol_clock_en = div_r[1:0] == 2'(SYMBOL_DIV - 1);
  assign lnk.byte_clock_en = div_r == 3'(BYTE_DIV - 1);
  // buffer clock strictly follows one of the two, never a third rate
  assign lnk.buffer_memory_clock_en = bm_fast_r ? lnk.symbol_clock_en
                                                : lnk.byte_clock_en;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic ph_wr_r;
  logic [7:0] ph_addr_r;
  logic [4:0] match_r;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (hready) begin
      ph_wr_r <= hsel && htrans[1] && hwrite;
      ph_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        H_CTRL: hrdata <= {31'h0, bm_fast_r};
        H_DREG: hrdata <= {16'h0000, lnk.reg_rdata};
        H_MATCH: hrdata <= {20'h00000, lnk.a_flag, lnk.c_flag, lnk.a_out, lnk.c_out,
                            3'h0, match_r};
        H_HREQ: hrdata <= {25'h0, lnk.queue_status_code, 1'b0,
                           lnk.host_service_request};
        H_FCWORD: hrdata <= {21'h0, lnk.da_next_word, lnk.da_lane, lnk.fc_byte};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register writes and link drive
  // ----------------------------------------------------------------
  logic wr_go;
  assign wr_go = ph_wr_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bm_fast_r <= 1'b0;
      match_r <= 5'h00;
      lnk.host_service_request <= HR_NONE;
      lnk.fc_word <= 32'h00000000;
      lnk.reg_addr <= 4'h0;
      lnk.reg_wdata <= 16'h0000;
      lnk.reg_write <= 1'b0;
    end else if (wr_go) begin
      case (ph_addr_r)
        H_CTRL: bm_fast_r <= hwdata[0];
        H_DREG: begin
          lnk.reg_addr <= hwdata[HD_ADDR_LO +: 4];
          lnk.reg_wdata <= hwdata[15:0];
          lnk.reg_write <= hwdata[HD_WRITE];
        end
        H_MATCH: match_r <= hwdata[4:0];
        H_HREQ: lnk.host_service_request <= hwdata[2:0];
        H_FCWORD: lnk.fc_word <= hwdata;
        default: ;
      endcase
    end
  end

  // one-cycle strobes follow the write that loaded their data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.reg_sel <= 1'b0;
      lnk.frame_eval <= 1'b0;
      lnk.fc_strobe <= 1'b0;
    end else begin
      lnk.reg_sel <= wr_go && ph_addr_r == H_DREG;
      lnk.frame_eval <= wr_go && ph_addr_r == H_MATCH && hwdata[5];
      lnk.fc_strobe <= wr_go && ph_addr_r == H_FCWORD;
    end
  end

  assign lnk.internal_address_match = match_r[0];
  assign lnk.external_address_match_n = !match_r[1];
  assign lnk.external_match_qualifier_n = !match_r[2];
  assign lnk.a_in = match_r[3];
  assign lnk.c_in = match_r[4];

endmodule : fmq_host

// ==== verif/fmq_monitor.sv ====
// link checks between the controller end and the device end
module fmq_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // clock enables
  input wire logic symbol_clock_en,
  input wire logic byte_clock_en,
  input wire logic buffer_memory_clock_en,
  // device port
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  // indicators
  input wire logic frame_eval,
  input wire logic internal_address_match,
  input wire logic external_address_match_n,
  input wire logic external_match_qualifier_n,
  input wire logic a_in,
  input wire logic c_in,
  input wire logic a_flag,
  input wire logic c_flag,
  input wire logic a_out,
  input wire logic c_out,
  // queues
  input wire logic [2:0] host_service_request,
  input wire logic [2:0] queue_status_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import fmq_pkg::*;
  logic [15:0] m1_r;
  logic [15:0] m3_r;
  logic [1:0] sel;
  logic full;
  logic [3:0] outs;
  logic [3:0] exp_ext;
  // ----------------------------------------
  // shadow of mode registers one and three
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m1_r <= 16'h0;
      m3_r <= 16'h0;
    end else if (reg_sel && reg_write && reg_addr == REG_MODE_ONE) begin
      m1_r <= reg_wdata;
    end else if (reg_sel && reg_write && reg_addr == REG_MODE_THREE) begin
      m3_r <= reg_wdata;
    end
  end
  assign sel = m3_r[5:4];
  always_comb begin
    case (sel)
      2'b00: full = m1_r[14:12] != OSM_CODE;
      2'b01: full = !(m3_r[2] && external_match_qualifier_n);
      default: full = m3_r[2] && !external_match_qualifier_n;
    endcase
  end
  assign exp_ext = full ? 4'hF : {2'b01, a_in, 1'b1};
  assign outs = {a_flag, c_flag, a_out, c_out};
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_SYMBOL_RATE: assert property (
    symbol_clock_en |=> !symbol_clock_en [*3] ##1 symbol_clock_en)
    else $error("symbol enable period wrong");
  AST_BYTE_RATE: assert property (
    byte_clock_en |=> !byte_clock_en [*7] ##1 byte_clock_en)
    else $error("byte enable period wrong");
  AST_BUF_CLOCK: assert property (
    (byte_clock_en |-> buffer_memory_clock_en) and (buffer_memory_clock_en |-> symbol_clock_en))
    else $error("buffer enable not byte or symbol");
  AST_IND_OFF: assert property (
    frame_eval && sel == 2'b11 |=> outs == {2'b00, $past(a_in), $past(c_in)})
    else $error("indicators touched while off");
  AST_IND_INT: assert property (
    frame_eval && sel != 2'b11 && internal_address_match |=> outs == 4'hF)
    else $error("internal match did not set all");
  AST_IND_NONE: assert property (
    frame_eval && sel != 2'b11 && !internal_address_match && external_address_match_n
    |=> outs == {2'b00, $past(a_in), $past(c_in)})
    else $error("no match did not pass bits");
  AST_IND_EXT: assert property (
    frame_eval && sel != 2'b11 && !internal_address_match && !external_address_match_n
    |=> outs == $past(exp_ext))
    else $error("external match indicators wrong");
  AST_QS_RSVD: assert property (
    queue_status_code != QS_RESERVED)
    else $error("reserved queue status driven");
  AST_QS_ASYNC1: assert property (
    buffer_memory_clock_en && host_service_request == HR_WR_ASYNC1
    |=> queue_status_code inside {QS_ASYNC1, QS_FULL, QS_AFULL})
    else $error("async one write status wrong");
  AST_QS_IDLE: assert property (
    buffer_memory_clock_en && host_service_request == HR_NONE |=> queue_status_code == QS_IDLE)
    else $error("status not idle without write");
  COV_IND_OFF: cover property (frame_eval && sel == 2'b11);
  COV_AFULL: cover property (queue_status_code == QS_AFULL [*5]);
  COV_FULL: cover property (queue_status_code == QS_FULL);
endmodule : fmq_monitor

// ==== verif/test_fddi_mac_indicator_queue_ctrl.sv ====
// self-checking bench for the controller and device ends
module test_fddi_mac_indicator_queue_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import fmq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int bad_count = 0;
  int compares = 0;
  always #5 hclk = ~hclk;
  fmq_if lnk (.hclk(hclk), .hresetn(hresetn));
  fmq_host u_fmq_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lnk(lnk.host));
  fmq_device #(.QDEPTH(16), .AFULL_LEVEL(12)) u_fmq_device (.hclk(hclk), .hresetn(hresetn),
    .lnk(lnk.dev));
  fmq_monitor u_fmq_monitor (.hclk(hclk), .hresetn(hresetn),
    .symbol_clock_en(lnk.symbol_clock_en), .byte_clock_en(lnk.byte_clock_en),
    .buffer_memory_clock_en(lnk.buffer_memory_clock_en), .reg_sel(lnk.reg_sel),
    .reg_write(lnk.reg_write), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .frame_eval(lnk.frame_eval), .internal_address_match(lnk.internal_address_match),
    .external_address_match_n(lnk.external_address_match_n),
    .external_match_qualifier_n(lnk.external_match_qualifier_n), .a_in(lnk.a_in),
    .c_in(lnk.c_in), .a_flag(lnk.a_flag), .c_flag(lnk.c_flag), .a_out(lnk.a_out),
    .c_out(lnk.c_out), .host_service_request(lnk.host_service_request),
    .queue_status_code(lnk.queue_status_code));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    repeat (2) @(posedge hclk);
  endtask : wr
  task automatic dev_wr(input logic [3:0] i, input logic [15:0] d);
    wr(H_DREG, {11'h0, 1'b1, i, d});
  endtask : dev_wr
  task automatic dev_rd(input logic [3:0] i);
    wr(H_DREG, {12'h0, i, 16'h0});
    ahb(1'b0, H_DREG, 32'h0);
  endtask : dev_rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    dev_rd(REG_MODE_TWO);
    chk(rd[15:0], 16'h8000);
    dev_rd(REG_MODE_THREE);
    chk(rd[15:0], 16'h0);
    dev_rd(REG_STATUS_ONE_UPPER);
    chk(rd[15:0], 16'h7);
    dev_rd(REG_STATUS_ONE_LOWER);
    chk(rd[15:0], 16'h0);
    dev_wr(REG_MODE_TWO, 16'h0);
    dev_rd(REG_MODE_TWO);
    chk(rd[15:0], 16'h0);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs
  task automatic t_ind;
    logic [3:0] e;
    logic fl;
    for (int s = 0; s < 4; s++)
      for (int o = 0; o < 2; o++)
        for (int q = 0; q < 2; q++) begin
          dev_wr(REG_MODE_ONE, o ? {1'b0, OSM_CODE, 12'h0} : 16'h0);
          dev_wr(REG_MODE_THREE, 16'(s << 4 | q << 2));
          // match bits: internal, external, qualifier, a_in, c_in, fire
          for (int m = 0; m < 32; m++) begin
            wr(H_MATCH, 32'(m + 32));
            chk(lnk.external_address_match_n, !m[1]);
            ahb(1'b0, H_MATCH, 32'h0);
            fl = s == 0 ? !o : s == 1 ? !(q && !m[2]) : (q && m[2]);
            if (s == 3 || !m[1:0]) e = {2'b00, m[3], m[4]};
            else if (m[0] || fl) e = 4'hF;
            else e = {2'b01, m[3], 1'b1};
            chk(rd[11:8], e);
          end
        end
  endtask : t_ind
  task automatic t_queue;
    int af;
    int fu;
    int a1;
    logic [2:0] snap;
    af = 0;
    fu = 0;
    a1 = 0;
    // symbol-rate fill outruns the byte-rate drain, so the queue tops up
    wr(H_CTRL, 32'h1);
    dev_wr(REG_MODE_THREE, 16'(1 << M3_AFULL_REPEAT));
    wr(H_HREQ, 32'(HR_WR_ASYNC1));
    repeat (300) begin
      @(negedge hclk);
      af += int'(lnk.queue_status_code === QS_AFULL);
      fu += int'(lnk.queue_status_code === QS_FULL);
      a1 += int'(lnk.queue_status_code === QS_ASYNC1);
    end
    chk(a1 > 0, 1'b1);
    chk(af > 8, 1'b1);
    chk(fu > 0, 1'b1);
    wr(H_HREQ, 32'h0);
    // snapshot, since the drain keeps running behind the commands
    dev_rd(REG_STATUS_ONE_UPPER);
    snap = rd[2:0];
    dev_wr(REG_CMD_ONE, 16'h0018);
    dev_wr(REG_CMD_TWO, 16'h0008);
    dev_wr(REG_CMD_TWO, 16'h0001);
    dev_wr(REG_CMD_TWO, 16'h0002);
    dev_rd(REG_STATUS_ONE_UPPER);
    chk(rd[2:0], snap);
    dev_wr(REG_CMD_ONE, {8'h0, CMD1_FLUSH_ASYNC1});
    dev_rd(REG_STATUS_ONE_UPPER);
    chk(rd[2:0], 3'b111);
  endtask : t_queue
  task automatic t_fc;
    int ln;
    for (int b = 0; b < 2; b++)
      for (int p = 0; p < 4; p++) begin
        dev_wr(REG_MODE_TWO, 16'(32'h8000 | b << 11));
        dev_wr(REG_MODE_THREE, 16'(p << 12));
        wr(H_FCWORD, 32'hA1B2C3D4);
        ahb(1'b0, H_FCWORD, 32'h0);
        ln = b ? (4 - p) % 4 : p;
        chk(rd[10:0], {ln == 3, 2'(ln + 1), 8'(32'hA1B2C3D4 >> (24 - 8 * ln))});
      end
  endtask : t_fc
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_ind;
    t_queue;
    t_fc;
    results;
  end
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    results;
  end
endmodule : test_fddi_mac_indicator_queue_ctrl
